// ---- verilog/vipl_layout_dec.sv ----
// Decoder of the front end control dword into indirect payload layout.
`timescale 1ns/1ns
`include "vipl_params.svh"
// Function
// - Flag clear: residual packed right after vector and weight/offset blocks.
// - Flag set: residual fetched at fixed residual source offset.
// - Presence code: 00 none, 01 vectors only, 11 both, 10 reserved.
// - Bits 23:16 are the fixed residual distance in dwords.
// - Weight/offset lands at register offset bits 12:8.
// - Weight/offset offset ignored when vector size is zero.
// - Inter residual lands at register offset bits 4:0.
// - Zero vector size: residual at first indirect register.
module vipl_layout_dec
  import vipl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        dword_valid,
  input  wire logic [31:0] ctrl_dword,
  input  wire vipl_mode_e  front_end_decode_mode,
  input  wire logic        mb_valid,
  input  wire logic [7:0]  vector_block_size,
  input  wire logic [7:0]  vec_wo_dw,
  output logic             fixed_res_r,
  output vipl_layout_e     layout_r,
  output logic             vectors_present_r,
  output logic             wo_present_r,
  output logic [7:0]       res_src_dw_r,
  output logic [4:0]       wo_reg_cfg_r,
  output logic [4:0]       res_reg_cfg_r,
  output logic             mbz_error_r,
  output logic             place_valid_r,
  output logic             wo_use_r,
  output logic [4:0]       wo_reg_r,
  output logic [4:0]       res_reg_r,
  output logic [7:0]       res_fetch_dw_r
);
  logic         fixed_res_nxt;
  vipl_layout_e layout_nxt;
  logic         vectors_present_nxt;
  logic         wo_present_nxt;
  logic [7:0]   res_src_dw_nxt;
  logic [4:0]   wo_reg_cfg_nxt;
  logic [4:0]   res_reg_cfg_nxt;
  logic         mbz_error_nxt;
  logic         place_valid_nxt;
  logic         wo_use_nxt;
  logic [4:0]   wo_reg_nxt;
  logic [4:0]   res_reg_nxt;
  logic [7:0]   res_fetch_dw_nxt;
  logic         p_wo_use;
  logic [4:0]   p_wo_reg;
  logic [4:0]   p_res_reg;
  logic [7:0]   p_fetch;
  logic         bad;

  vipl_mb_place u_place (
    .fixed_res         (fixed_res_r),
    .res_src_dw        (res_src_dw_r),
    .wo_reg            (wo_reg_cfg_r),
    .res_reg           (res_reg_cfg_r),
    .vector_block_size (vector_block_size),
    .vec_wo_dw         (vec_wo_dw),
    .wo_use            (p_wo_use),
    .wo_reg_out        (p_wo_reg),
    .res_reg_out       (p_res_reg),
    .res_fetch_dw      (p_fetch)
  );

  // Configuration capture from the state command.
  always_comb begin
    fixed_res_nxt       = fixed_res_r;
    layout_nxt          = layout_r;
    vectors_present_nxt = vectors_present_r;
    wo_present_nxt      = wo_present_r;
    res_src_dw_nxt      = res_src_dw_r;
    wo_reg_cfg_nxt      = wo_reg_cfg_r;
    res_reg_cfg_nxt     = res_reg_cfg_r;
    mbz_error_nxt       = mbz_error_r;
    bad                 = 1'b0;
    if (dword_valid) begin
      if (front_end_decode_mode == VIPL_ALT_CODEC_TRANSFORM_MODE) begin
        bad = (ctrl_dword != 32'h0000_0000);
        fixed_res_nxt       = 1'b0;
        layout_nxt          = VIPL_NO_VECTORS_LAYOUT;
        vectors_present_nxt = 1'b0;
        wo_present_nxt      = 1'b0;
        res_src_dw_nxt      = 8'h00;
        wo_reg_cfg_nxt      = 5'h00;
        res_reg_cfg_nxt     = 5'h00;
      end else begin
        bad = ((ctrl_dword & `VIPL_RSVD_MASK) != 32'h0000_0000);
        fixed_res_nxt = ctrl_dword[`VIPL_FIXED_RES_BIT];
        if (front_end_decode_mode == VIPL_MOTION_COMP_DECODE_MODE &&
            !ctrl_dword[`VIPL_FIXED_RES_BIT]) begin
          bad = 1'b1;
        end
        layout_nxt = vipl_layout_e'(ctrl_dword[`VIPL_PRESENCE_HI:`VIPL_PRESENCE_LO]);
        vectors_present_nxt = ctrl_dword[`VIPL_PRESENCE_LO];
        wo_present_nxt = (ctrl_dword[`VIPL_PRESENCE_HI:`VIPL_PRESENCE_LO] == `VIPL_CODE_BOTH);
        if (ctrl_dword[`VIPL_PRESENCE_HI:`VIPL_PRESENCE_LO] == `VIPL_CODE_RESERVED) begin
          bad = 1'b1;
        end
        res_src_dw_nxt = ctrl_dword[`VIPL_RES_SRC_HI:`VIPL_RES_SRC_LO];
        if ((res_src_dw_nxt & `VIPL_RES_SRC_ALIGN) != 8'h00) begin
          bad = 1'b1;
        end
        if (!fixed_res_nxt && res_src_dw_nxt != 8'h00) begin
          bad = 1'b1;
        end
        wo_reg_cfg_nxt  = ctrl_dword[`VIPL_WO_REG_HI:`VIPL_WO_REG_LO];
        res_reg_cfg_nxt = ctrl_dword[`VIPL_RES_REG_HI:`VIPL_RES_REG_LO];
        if (ctrl_dword[`VIPL_PRESENCE_HI:`VIPL_PRESENCE_LO] == `VIPL_CODE_NO_VECTORS &&
            (wo_reg_cfg_nxt != 5'h00 || res_reg_cfg_nxt != 5'h00)) begin
          bad = 1'b1;
        end
        if (res_reg_cfg_nxt < wo_reg_cfg_nxt && wo_present_nxt) begin
          bad = 1'b1;
        end
      end
      mbz_error_nxt = bad;
    end
  end

  // Per-macroblock placement, registered one cycle after mb_valid.
  always_comb begin
    place_valid_nxt  = mb_valid;
    wo_use_nxt       = wo_use_r;
    wo_reg_nxt       = wo_reg_r;
    res_reg_nxt      = res_reg_r;
    res_fetch_dw_nxt = res_fetch_dw_r;
    if (mb_valid) begin
      wo_use_nxt       = p_wo_use && wo_present_r;
      wo_reg_nxt       = wo_present_r ? p_wo_reg : 5'h00;
      res_reg_nxt      = p_res_reg;
      res_fetch_dw_nxt = p_fetch;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fixed_res_r       <= 1'b0;
      layout_r          <= VIPL_NO_VECTORS_LAYOUT;
      vectors_present_r <= 1'b0;
      wo_present_r      <= 1'b0;
      res_src_dw_r      <= 8'h00;
      wo_reg_cfg_r      <= 5'h00;
      res_reg_cfg_r     <= 5'h00;
      mbz_error_r       <= 1'b0;
      place_valid_r     <= 1'b0;
      wo_use_r          <= 1'b0;
      wo_reg_r          <= 5'h00;
      res_reg_r         <= 5'h00;
      res_fetch_dw_r    <= 8'h00;
    end else begin
      fixed_res_r       <= fixed_res_nxt;
      layout_r          <= layout_nxt;
      vectors_present_r <= vectors_present_nxt;
      wo_present_r      <= wo_present_nxt;
      res_src_dw_r      <= res_src_dw_nxt;
      wo_reg_cfg_r      <= wo_reg_cfg_nxt;
      res_reg_cfg_r     <= res_reg_cfg_nxt;
      mbz_error_r       <= mbz_error_nxt;
      place_valid_r     <= place_valid_nxt;
      wo_use_r          <= wo_use_nxt;
      wo_reg_r          <= wo_reg_nxt;
      res_reg_r         <= res_reg_nxt;
      res_fetch_dw_r    <= res_fetch_dw_nxt;
    end
  end

  chk_fixed_fetch: assert property (
    @(posedge clk_sys) disable iff (rst)
    mb_valid && fixed_res_r && !dword_valid |=> res_fetch_dw_r == $past(res_src_dw_r))
    else $error("fixed residual fetch offset wrong");
  chk_packed_fetch: assert property (
    @(posedge clk_sys) disable iff (rst)
    mb_valid && !fixed_res_r |=> res_fetch_dw_r == $past(vec_wo_dw))
    else $error("packed residual fetch offset wrong");
  chk_intra_res: assert property (
    @(posedge clk_sys) disable iff (rst)
    mb_valid && vector_block_size == 8'h00 |=> res_reg_r == 5'h00 && !wo_use_r)
    else $error("intra residual not at first register");
  chk_inter_res: assert property (
    @(posedge clk_sys) disable iff (rst)
    mb_valid && vector_block_size != 8'h00 |=> res_reg_r == $past(res_reg_cfg_r))
    else $error("inter residual register wrong");
  chk_wo_place: assert property (
    @(posedge clk_sys) disable iff (rst)
    mb_valid && vector_block_size != 8'h00 && wo_present_r
      |=> wo_use_r && wo_reg_r == $past(wo_reg_cfg_r))
    else $error("weight offset register wrong");
  chk_wo_ignore: assert property (
    @(posedge clk_sys) disable iff (rst)
    mb_valid && vector_block_size == 8'h00 |=> wo_reg_r == 5'h00)
    else $error("weight offset used for intra block");
  chk_presence_code: assert property (
    @(posedge clk_sys) disable iff (rst)
    dword_valid && front_end_decode_mode != VIPL_ALT_CODEC_TRANSFORM_MODE
      |=> vectors_present_r == $past(ctrl_dword[24])
          && wo_present_r == ($past(ctrl_dword[25:24]) == 2'h3))
    else $error("presence code decode wrong");
  chk_src_field: assert property (
    @(posedge clk_sys) disable iff (rst)
    dword_valid && front_end_decode_mode != VIPL_ALT_CODEC_TRANSFORM_MODE
      |=> res_src_dw_r == $past(ctrl_dword[23:16]))
    else $error("residual source offset not captured");
  chk_rsvd_flag: assert property (
    @(posedge clk_sys) disable iff (rst)
    dword_valid && (ctrl_dword & 32'hF800_E0E0) != 32'h0 |=> mbz_error_r)
    else $error("reserved bits not flagged");
endmodule : vipl_layout_dec

// ---- include/vipl_params.svh ----
// Field positions, widths and reset values of the front end control dword.
`ifndef VIPL_PARAMS_SVH
`define VIPL_PARAMS_SVH
`define VIPL_FIXED_RES_BIT    26
`define VIPL_PRESENCE_HI      25
`define VIPL_PRESENCE_LO      24
`define VIPL_RES_SRC_HI       23
`define VIPL_RES_SRC_LO       16
`define VIPL_WO_REG_HI        12
`define VIPL_WO_REG_LO        8
`define VIPL_RES_REG_HI       4
`define VIPL_RES_REG_LO       0
`define VIPL_RSVD_MASK        32'hF800_E0E0
`define VIPL_RES_SRC_ALIGN    8'h07
`define VIPL_DWORD_RESET      32'h0000_0000
`define VIPL_CODE_NO_VECTORS  2'h0
`define VIPL_CODE_NO_WO       2'h1
`define VIPL_CODE_RESERVED    2'h2
`define VIPL_CODE_BOTH        2'h3
`endif

// ---- include/vipl_pkg.sv ----
// Types shared by the indirect payload layout decoder.
package vipl_pkg;
  typedef enum logic [1:0] {
    VIPL_INVERSE_TRANSFORM_DECODE_MODE,
    VIPL_MOTION_COMP_DECODE_MODE,
    VIPL_ALT_CODEC_TRANSFORM_MODE,
    VIPL_OTHER_MODE
  } vipl_mode_e;

  typedef enum logic [1:0] {
    VIPL_NO_VECTORS_LAYOUT,
    VIPL_NO_WEIGHT_OFFSET_LAYOUT,
    VIPL_LAYOUT_RESERVED,
    VIPL_BOTH_LAYOUT
  } vipl_layout_e;
endpackage : vipl_pkg

// ---- verilog/vipl_mb_place.sv ----
// Per-macroblock placement of weight/offset and residual data.
`timescale 1ns/1ns
module vipl_mb_place
  import vipl_pkg::*;
(
  input  wire logic       fixed_res,
  input  wire logic [7:0] res_src_dw,
  input  wire logic [4:0] wo_reg,
  input  wire logic [4:0] res_reg,
  input  wire logic [7:0] vector_block_size,
  input  wire logic [7:0] vec_wo_dw,
  output logic            wo_use,
  output logic [4:0]      wo_reg_out,
  output logic [4:0]      res_reg_out,
  output logic [7:0]      res_fetch_dw
);
  logic inter_mb;

  assign inter_mb = (vector_block_size != 8'h00);

  always_comb begin
    wo_use     = inter_mb;
    wo_reg_out = inter_mb ? wo_reg : 5'h00;
    res_reg_out = res_reg;
    if (!inter_mb) begin
      res_reg_out = 5'h00;
    end
    if (fixed_res) begin
      res_fetch_dw = res_src_dw;
    end else begin
      res_fetch_dw = vec_wo_dw;
    end
  end
endmodule : vipl_mb_place

// ---- testbench/vipl_sw_model.sv ----
// Driver software model that builds and issues the front end control dword.
`timescale 1ns/1ns
`include "vipl_params.svh"
module vipl_sw_model
  import vipl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        send,
  input  wire logic        legal,
  input  wire logic [31:0] raw_dw,
  input  wire vipl_mode_e  mode_in,
  output logic             dword_valid,
  output logic [31:0]      ctrl_dword,
  output vipl_mode_e       front_end_decode_mode
);
  logic [31:0] d;
  // Illegal requests pass raw so the bench can provoke the error flag.
  always_comb begin
    d = raw_dw;
    d = d & ~`VIPL_RSVD_MASK;
    d[23:16] = d[23:16] & 8'hF8;
    if (mode_in == VIPL_MOTION_COMP_DECODE_MODE) d[26] = 1'b1;
    if (!d[26]) d[23:16] = 8'h00;
    if (d[25:24] == 2'h2) d[25:24] = 2'h3;
    if (d[25:24] == 2'h0) d[12:0] = 13'h0000;
    if (d[25:24] == 2'h3 && d[4:0] < d[12:8]) d[4:0] = d[12:8];
    if (mode_in == VIPL_ALT_CODEC_TRANSFORM_MODE) d = 32'h0000_0000;
  end
  always_ff @(posedge clk_sys) begin
    dword_valid           <= send && !rst;
    ctrl_dword            <= legal ? d : raw_dw;
    front_end_decode_mode <= mode_in;
  end
endmodule : vipl_sw_model

// ---- testbench/video_indirect_payload_layout_tb_top.sv ----
// Self-checking bench for the indirect payload layout decoder.
`timescale 1ns/1ns
module video_indirect_payload_layout_tb_top
  import vipl_pkg::*;
;
  logic clk_sys = 0, rst = 1, send = 0, legal = 0, mb_valid = 0;
  logic [31:0] raw_dw = 0, ctrl_dword;
  logic [7:0] size = 0, vw = 0, res_fetch_dw_r, res_src_dw_r;
  vipl_mode_e mode_in = VIPL_INVERSE_TRANSFORM_DECODE_MODE, fe_mode;
  vipl_layout_e layout_r;
  logic dword_valid, fixed_res_r, vectors_present_r, wo_present_r, mbz_error_r;
  logic place_valid_r, wo_use_r;
  logic [4:0] wo_reg_cfg_r, res_reg_cfg_r, wo_reg_r, res_reg_r;
  int errors = 0, tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  vipl_sw_model sw_u (.clk_sys(clk_sys), .rst(rst), .send(send), .legal(legal),
    .raw_dw(raw_dw), .mode_in(mode_in), .dword_valid(dword_valid),
    .ctrl_dword(ctrl_dword), .front_end_decode_mode(fe_mode));
  vipl_layout_dec dut_u (.clk_sys(clk_sys), .rst(rst), .dword_valid(dword_valid),
    .ctrl_dword(ctrl_dword), .front_end_decode_mode(fe_mode), .mb_valid(mb_valid),
    .vector_block_size(size), .vec_wo_dw(vw), .fixed_res_r(fixed_res_r),
    .layout_r(layout_r), .vectors_present_r(vectors_present_r),
    .wo_present_r(wo_present_r), .res_src_dw_r(res_src_dw_r),
    .wo_reg_cfg_r(wo_reg_cfg_r), .res_reg_cfg_r(res_reg_cfg_r),
    .mbz_error_r(mbz_error_r), .place_valid_r(place_valid_r), .wo_use_r(wo_use_r),
    .wo_reg_r(wo_reg_r), .res_reg_r(res_reg_r), .res_fetch_dw_r(res_fetch_dw_r));
  task automatic compare(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : compare
  task automatic cfg(logic [31:0] dw, vipl_mode_e m, logic ok);
    @(posedge clk_sys);
    send <= 1;
    raw_dw <= dw;
    mode_in <= m;
    legal <= ok;
    @(posedge clk_sys);
    send <= 0;
    @(posedge clk_sys);
    #1;
  endtask : cfg
  task automatic mb(logic [7:0] s, logic [7:0] v);
    @(posedge clk_sys);
    mb_valid <= 1;
    size <= s;
    vw <= v;
    @(posedge clk_sys);
    mb_valid <= 0;
    #1;
    compare("place_valid", place_valid_r, 1);
    @(posedge clk_sys);
    #1;
    compare("place_pulse", place_valid_r, 0);
  endtask : mb
  task automatic place(logic u, logic [4:0] w, logic [4:0] r, logic [7:0] f);
    compare("wo_use", wo_use_r, u);
    compare("wo_reg", wo_reg_r, w);
    compare("res_reg", res_reg_r, r);
    compare("res_fetch", res_fetch_dw_r, f);
  endtask : place
  task automatic test_codes();
    for (int c = 0; c < 4; c++) begin
      cfg({6'h00, c[1:0], 24'h00_0000}, VIPL_INVERSE_TRANSFORM_DECODE_MODE, 0);
      compare("layout", layout_r, c);
      compare("vectors", vectors_present_r, c[0]);
      compare("weights", wo_present_r, c == 3);
      compare("code_err", mbz_error_r, c == 2);
    end
  endtask : test_codes
  task automatic test_fixed();
    cfg(32'h0718_0406, VIPL_MOTION_COMP_DECODE_MODE, 1);
    compare("src", res_src_dw_r, 8'h18);
    compare("err", mbz_error_r, 0);
    compare("fixed", fixed_res_r, 1);
    compare("wo_cfg", wo_reg_cfg_r, 5'h04);
    compare("res_cfg", res_reg_cfg_r, 5'h06);
    mb(8'h04, 8'h09);
    place(1, 5'h04, 5'h06, 8'h18);
    // Intra macroblock straight after an inter one.
    mb(8'h00, 8'h09);
    place(0, 5'h00, 5'h00, 8'h18);
    cfg(32'h0100_0003, VIPL_INVERSE_TRANSFORM_DECODE_MODE, 1);
    mb(8'h02, 8'h09);
    place(0, 5'h00, 5'h03, 8'h09);
  endtask : test_fixed
  task automatic test_legal();
    // Raw dwords that break software rules, legalised by the software model.
    cfg(32'hFF1C_1F1F, VIPL_MOTION_COMP_DECODE_MODE, 1);
    compare("lg_err", mbz_error_r, 0);
    compare("lg_src", res_src_dw_r, 8'h18);
    compare("lg_wo", wo_reg_cfg_r, 5'h1F);
    cfg(32'h0208_0604, VIPL_MOTION_COMP_DECODE_MODE, 1);
    compare("lg_fixed", fixed_res_r, 1);
    compare("lg_res", res_reg_cfg_r, 5'h06);
    compare("lg_err", mbz_error_r, 0);
    cfg(32'h0008_0406, VIPL_INVERSE_TRANSFORM_DECODE_MODE, 1);
    compare("lg_src", res_src_dw_r, 8'h00);
    compare("lg_wo", wo_reg_cfg_r, 5'h00);
    compare("lg_err", mbz_error_r, 0);
    cfg(32'h0000_0001, VIPL_ALT_CODEC_TRANSFORM_MODE, 1);
    compare("lg_err", mbz_error_r, 0);
  endtask : test_legal
  task automatic bad(logic [31:0] dw, vipl_mode_e m);
    cfg(dw, m, 0);
    compare("mbz_error", mbz_error_r, 1);
  endtask : bad
  task automatic test_errors();
    bad(32'h8718_0406, VIPL_MOTION_COMP_DECODE_MODE);
    mb(8'h04, 8'h09);
    place(1, 5'h04, 5'h06, 8'h18);
    bad(32'h0704_0406, VIPL_MOTION_COMP_DECODE_MODE);
    bad(32'h0300_0406, VIPL_MOTION_COMP_DECODE_MODE);
    bad(32'h0308_0406, VIPL_INVERSE_TRANSFORM_DECODE_MODE);
    bad(32'h0000_0400, VIPL_INVERSE_TRANSFORM_DECODE_MODE);
    bad(32'h0718_0604, VIPL_INVERSE_TRANSFORM_DECODE_MODE);
    bad(32'h0000_0001, VIPL_ALT_CODEC_TRANSFORM_MODE);
    compare("alt_cfg", res_reg_cfg_r, 0);
    compare("alt_fixed", fixed_res_r, 0);
  endtask : test_errors
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    #1;
    compare("reset", {fixed_res_r, layout_r, mbz_error_r, res_fetch_dw_r}, 0);
    test_codes();
    test_fixed();
    test_legal();
    test_errors();
    tally_and_finish();
  end
  // The run needs about 70 cycles; 2000 leaves ample margin.
  initial begin
    repeat (2000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
endmodule : video_indirect_payload_layout_tb_top
